// File: rtl/opcr_top.sv
// output pair control registers behind an ahb-lite slave
// Notes on behaviour
// - bit 7 of the first register picks synth_a (0) or synth_b (1) for both channels, reset 1.
// - bits 6:5 of the first register set channel 0 format off, ac diff, hcsl, cmos, reset 1.
// - bits 6:5 of the second register set channel 1 format with the same codes, reset 1.
// - bits 4:3 of the first register set channel 0 tail current or cmos positive leg, reset 2.
// - bits 4:3 of the second register set channel 1 tail current or positive leg, reset 2.
// - bits 2:1 of the first register set channel 0 hcsl load or cmos negative leg, reset 0.
// - bits 2:1 of the second register set channel 1 hcsl load or negative leg, reset 0.
`timescale 1ns/1ns
`include "opcr_regs.svh"
module opcr_top
	import opcr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic pair_source_select,
	output opcr_chan_s first_channel,
	output opcr_chan_s second_channel,
	output logic first_channel_off,
	output logic second_channel_off,
	output logic [1:0] first_channel_drive_a,
	output logic [1:0] first_channel_drive_b,
	output logic [1:0] second_channel_drive_a,
	output logic [1:0] second_channel_drive_b
);
	opcr_req_s req_q;
	logic dphase_q;
	logic pair_mux_q;
	logic [7:0] first_rd;
	logic [7:0] second_rd;
	logic addr_ok;
	logic take;
	logic wr_first;
	logic wr_second;
	opcr_chan_s chan_arr [2];
	logic [1:0] chan_wr;

	// word index from a byte address, used at decode
	function automatic logic [7:0] opcr_index(input logic [31:0] a);
		opcr_index = a[9:2];
	endfunction : opcr_index

	// write strobe of one register index during a data phase
	function automatic logic opcr_wr_hit(input logic ph, input opcr_req_s r, input logic [7:0] idx);
		opcr_wr_hit = ph && r.write && (r.addr == idx);
	endfunction : opcr_wr_hit

	// address phase accepted on a valid whole-word transfer to this bank
	assign addr_ok = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
	assign take = hsel && hready && (htrans == `OPCR_HTRANS_NONSEQ
		|| htrans == `OPCR_HTRANS_SEQ) && hsize == `OPCR_HSIZE_WORD;

	// captured address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
			dphase_q <= 1'b0;
		end else if (hready) begin
			dphase_q <= take && addr_ok;
			req_q.addr <= opcr_index(haddr);
			req_q.write <= hwrite;
		end
	end

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wr_first = opcr_wr_hit(dphase_q, req_q, `OPCR_IDX_FIRST);
	assign wr_second = opcr_wr_hit(dphase_q, req_q, `OPCR_IDX_SECOND);

	// source mux bit of the pair
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pair_mux_q <= `OPCR_RST_MUX;
		end else if (wr_first) begin
			pair_mux_q <= hwdata[`OPCR_MUX_BIT];
		end
	end

	// channel fields, one instance per channel, bit 7 never stored
	assign chan_wr = {wr_second, wr_first};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_chan
			opcr_chan_field opcr_chan_field_inst (
				.hclk(hclk),
				.hresetn(hresetn),
				.wr_en(chan_wr[g]),
				.wr_data(hwdata[7:0]),
				.chan_q(chan_arr[g])
			);
		end
	endgenerate
	assign first_channel = chan_arr[0];
	assign second_channel = chan_arr[1];

	// read images with reserved bits zero
	assign first_rd = {pair_mux_q, first_channel.format, first_channel.drive_a,
		first_channel.drive_b, 1'b0};
	assign second_rd = {1'b0, second_channel.format, second_channel.drive_a,
		second_channel.drive_b, 1'b0};

	// read data mux, unmapped reads zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dphase_q && !req_q.write) begin
			case (req_q.addr)
				`OPCR_IDX_FIRST: hrdata = {24'h00_0000, first_rd};
				`OPCR_IDX_SECOND: hrdata = {24'h00_0000, second_rd};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// driver controls
	assign pair_source_select = pair_mux_q;
	assign first_channel_off = (first_channel.format == OPCR_FMT_OFF);
	assign second_channel_off = (second_channel.format == OPCR_FMT_OFF);
	assign first_channel_drive_a = first_channel.drive_a;
	assign first_channel_drive_b = first_channel.drive_b;
	assign second_channel_drive_a = second_channel.drive_a;
	assign second_channel_drive_b = second_channel.drive_b;

	// assertion clock and reset for the whole bank
	default clocking cb_bank @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// data phase of a write or a read to each register
	sequence seq_wr_first;
		dphase_q && req_q.write && req_q.addr == `OPCR_IDX_FIRST;
	endsequence
	sequence seq_wr_second;
		dphase_q && req_q.write && req_q.addr == `OPCR_IDX_SECOND;
	endsequence
	sequence seq_rd_first;
		dphase_q && !req_q.write && req_q.addr == `OPCR_IDX_FIRST;
	endsequence
	sequence seq_rd_second;
		dphase_q && !req_q.write && req_q.addr == `OPCR_IDX_SECOND;
	endsequence
	// accepted write address phase, then its data phase
	sequence seq_path_first;
		take && addr_ok && hwrite && opcr_index(haddr) == `OPCR_IDX_FIRST ##1 dphase_q;
	endsequence
	sequence seq_path_second;
		take && addr_ok && hwrite && opcr_index(haddr) == `OPCR_IDX_SECOND ##1 dphase_q;
	endsequence

	// a write to the first register lands next cycle
	AST_MUX_WRITE: assert property (
		seq_wr_first |=> pair_source_select == $past(hwdata[7]))
		else $error("pair source select did not follow write");

	// channel 0 format follows its write
	AST_FMT0_WRITE: assert property (
		seq_wr_first |=> first_channel.format == $past(hwdata[6:5]))
		else $error("channel 0 format did not follow write");

	// channel 1 format follows its write
	AST_FMT1_WRITE: assert property (
		seq_wr_second |=> second_channel.format == $past(hwdata[6:5]))
		else $error("channel 1 format did not follow write");

	// channel 0 drive a follows its write
	AST_DRA0_WRITE: assert property (
		seq_wr_first |=> first_channel_drive_a == $past(hwdata[4:3]))
		else $error("channel 0 drive a did not follow write");

	// channel 1 drive a follows its write
	AST_DRA1_WRITE: assert property (
		seq_wr_second |=> second_channel_drive_a == $past(hwdata[4:3]))
		else $error("channel 1 drive a did not follow write");

	// channel 0 drive b follows its write
	AST_DRB0_WRITE: assert property (
		seq_wr_first |=> first_channel_drive_b == $past(hwdata[2:1]))
		else $error("channel 0 drive b did not follow write");

	// channel 1 drive b follows its write
	AST_DRB1_WRITE: assert property (
		seq_wr_second |=> second_channel_drive_b == $past(hwdata[2:1]))
		else $error("channel 1 drive b did not follow write");

	// reserved bits never read as one
	AST_RSVD_ZERO: assert property (
		hrdata[0] == 1'b0 && (req_q.addr != `OPCR_IDX_SECOND || hrdata[7] == 1'b0)
		&& hrdata[31:8] == 24'h00_0000)
		else $error("reserved bits read nonzero");

	// off flags track the format fields
	AST_OFF_FLAG: assert property (
		first_channel_off == (first_channel.format == OPCR_FMT_OFF)
		&& second_channel_off == (second_channel.format == OPCR_FMT_OFF))
		else $error("channel off flag mismatches format");

	// nothing moves without a write
	AST_WRITE_HOLD: assert property (
		!(dphase_q && req_q.write) |=> $stable(first_rd) && $stable(second_rd))
		else $error("register changed without a write");

	// full path from address phase to the mux bit
	AST_MUX_PATH: assert property (
		seq_path_first |=> pair_source_select == $past(hwdata[7]))
		else $error("mux bit lost on the write path");

	// full path from address phase to channel 0 format
	AST_FMT0_PATH: assert property (
		seq_path_first |=> first_channel.format == $past(hwdata[6:5]))
		else $error("channel 0 format lost on the write path");

	// full path from address phase to channel 1 format
	AST_FMT1_PATH: assert property (
		seq_path_second |=> second_channel.format == $past(hwdata[6:5]))
		else $error("channel 1 format lost on the write path");

	// bit 7 of the second register does not reach the mux
	AST_SECOND_KEEPS_MUX: assert property (
		seq_wr_second |=> $stable(pair_source_select))
		else $error("second register write moved the mux");

	// second register write leaves channel 0 alone
	AST_SECOND_KEEPS_FIRST: assert property (
		seq_wr_second |=> $stable(first_channel))
		else $error("second register write moved channel 0");

	// first register write leaves channel 1 alone
	AST_FIRST_KEEPS_SECOND: assert property (
		seq_wr_first |=> $stable(second_channel))
		else $error("first register write moved channel 1");

	// readback of the first register
	AST_RD_FIRST: assert property (
		seq_rd_first |-> hrdata[7:0] == {pair_source_select, first_channel, 1'b0})
		else $error("first register readback wrong");

	// readback of the second register
	AST_RD_SECOND: assert property (
		seq_rd_second |-> hrdata[7:0] == {1'b0, second_channel, 1'b0})
		else $error("second register readback wrong");

	// top bit of the second register reads zero
	AST_SECOND_BIT7: assert property (
		seq_rd_second |-> hrdata[7] == 1'b0)
		else $error("second register bit 7 read nonzero");

	// read data is zero outside a read data phase
	AST_RD_IDLE: assert property (
		!(dphase_q && !req_q.write) |-> hrdata == 32'h0000_0000)
		else $error("read data outside a read phase");

	// write data phase drives no read data
	AST_WRITE_NO_READ: assert property (
		dphase_q && req_q.write |-> hrdata == 32'h0000_0000)
		else $error("read data during a write phase");

	// unmapped reads return zero
	AST_UNMAPPED_RD: assert property (
		dphase_q && !req_q.write && req_q.addr != `OPCR_IDX_FIRST
		&& req_q.addr != `OPCR_IDX_SECOND |-> hrdata == 32'h0000_0000)
		else $error("unmapped read nonzero");

	// no wait states ever
	AST_READY_HIGH: assert property (
		hreadyout == 1'b1)
		else $error("ready dropped");

	// response always okay
	AST_RESP_OKAY: assert property (
		hresp == 1'b0)
		else $error("error response seen");

	// sizes other than a word are not taken
	AST_SIZE_REFUSED: assert property (
		hsel && hready && hsize != `OPCR_HSIZE_WORD |=> !dphase_q)
		else $error("non-word transfer taken");

	// misaligned addresses are not taken
	AST_ALIGN_REFUSED: assert property (
		hsel && hready && haddr[1:0] != 2'h0 |=> !dphase_q)
		else $error("misaligned transfer taken");

	// addresses beyond the bank are not taken
	AST_RANGE_REFUSED: assert property (
		hready && haddr[31:10] != 22'h00_0000 |=> !dphase_q)
		else $error("out of range transfer taken");

	// idle and busy transfers are not taken
	AST_IDLE_REFUSED: assert property (
		hready && !htrans[1] |=> !dphase_q)
		else $error("idle transfer taken");

	// no transfer without select
	AST_NOSEL_REFUSED: assert property (
		hready && !hsel |=> !dphase_q)
		else $error("unselected transfer taken");

	// accepted address phase is captured for the data phase
	AST_TAKE_CAPTURE: assert property (
		take && addr_ok |=> dphase_q && req_q.addr == $past(haddr[9:2])
		&& req_q.write == $past(hwrite))
		else $error("address phase not captured");
endmodule : opcr_top

// File: rtl/opcr_regs.svh
// register offsets, field positions and reset values for the output pair control bank
`ifndef OPCR_REGS_SVH
`define OPCR_REGS_SVH
// offsets 0x1f and 0x20 are not both multiples of four: they are word indices
`define OPCR_IDX_FIRST 8'h1f
`define OPCR_IDX_SECOND 8'h20
`define OPCR_MUX_BIT 7
`define OPCR_FMT_HI 6
`define OPCR_FMT_LO 5
`define OPCR_DRA_HI 4
`define OPCR_DRA_LO 3
`define OPCR_DRB_HI 2
`define OPCR_DRB_LO 1
`define OPCR_RST_MUX 1'h1
`define OPCR_RST_FMT 2'h1
`define OPCR_RST_DRA 2'h2
`define OPCR_RST_DRB 2'h0
`define OPCR_HSIZE_WORD 3'h2
`define OPCR_HTRANS_NONSEQ 2'h2
`define OPCR_HTRANS_SEQ 2'h3
`endif

// File: rtl/opcr_pkg.sv
// types of the output pair control bank
package opcr_pkg;
	typedef enum logic [1:0] {
		OPCR_FMT_OFF = 2'h0,
		OPCR_FMT_ACDIFF = 2'h1,
		OPCR_FMT_HCSL = 2'h2,
		OPCR_FMT_CMOS = 2'h3
	} opcr_fmt_e;
	typedef enum logic [1:0] {
		OPCR_LEG_TRI = 2'h0,
		OPCR_LEG_LOW = 2'h1,
		OPCR_LEG_INV = 2'h2,
		OPCR_LEG_TRUE = 2'h3
	} opcr_leg_e;
	typedef struct packed {
		opcr_fmt_e format;
		logic [1:0] drive_a;
		logic [1:0] drive_b;
	} opcr_chan_s;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
	} opcr_req_s;
endpackage : opcr_pkg

// File: rtl/opcr_chan_field.sv
// one channel's format and drive fields, with reset value and update
`timescale 1ns/1ns
`include "opcr_regs.svh"
module opcr_chan_field
	import opcr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output opcr_chan_s chan_q
);
	// field store, reserved bits are not kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_q.format <= opcr_fmt_e'(`OPCR_RST_FMT);
			chan_q.drive_a <= `OPCR_RST_DRA;
			chan_q.drive_b <= `OPCR_RST_DRB;
		end else if (wr_en) begin
			chan_q.format <= opcr_fmt_e'(wr_data[`OPCR_FMT_HI:`OPCR_FMT_LO]);
			chan_q.drive_a <= wr_data[`OPCR_DRA_HI:`OPCR_DRA_LO];
			chan_q.drive_b <= wr_data[`OPCR_DRB_HI:`OPCR_DRB_LO];
		end
	end
endmodule : opcr_chan_field

// File: verif/opcr_tb_top.sv
// self-checking bench for the output pair control registers over ahb-lite
`timescale 1ns/1ns
`include "opcr_regs.svh"
module opcr_tb_top import opcr_pkg::*;;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic hreadyout, hresp, pss, fo0, fo1;
	logic [31:0] hrdata;
	opcr_chan_s ch0, ch1;
	logic [1:0] da0, db0, da1, db1;
	int error_cnt = 0;
	int checked = 0;
	localparam logic [31:0] a_first = {22'h00_0000, `OPCR_IDX_FIRST, 2'h0};
	localparam logic [31:0] a_second = {22'h00_0000, `OPCR_IDX_SECOND, 2'h0};
	// single slave: its ready is the bus ready
	opcr_top opcr_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pair_source_select(pss),
		.first_channel(ch0), .second_channel(ch1), .first_channel_off(fo0),
		.second_channel_off(fo1), .first_channel_drive_a(da0), .first_channel_drive_b(db0),
		.second_channel_drive_a(da1), .second_channel_drive_b(db1));
	// 100 mhz clock
	initial forever #5 hclk = ~hclk;
	task automatic complete_run();
		if (error_cnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// look at ready just before each edge, so the edge samples the same value
	task automatic wait_rdy();
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 16) begin
				error_cnt++;
				complete_run();
			end
			@(negedge hclk);
		end
	endtask : wait_rdy
	// one single transfer of the given size: address phase, then data phase
	task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= `OPCR_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		hsize <= s;
		wait_rdy();
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : xfer
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, `OPCR_HSIZE_WORD, d, r);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(a, 1'b0, `OPCR_HSIZE_WORD, 32'h0, r);
		chk("rdata", r, exp);
	endtask : rd
	function automatic logic [31:0] enc(input logic m, input opcr_chan_s c);
		return {24'h00_0000, m, c, 1'b0};
	endfunction : enc
	task automatic chk_ports(input logic m, input opcr_chan_s c0, input opcr_chan_s c1);
		chk("mux", {31'h0, pss}, {31'h0, m});
		chk("ch0", {26'h0, ch0}, {26'h0, c0});
		chk("ch1", {26'h0, ch1}, {26'h0, c1});
		chk("drv0", {28'h0, da0, db0}, {28'h0, c0.drive_a, c0.drive_b});
		chk("drv1", {28'h0, da1, db1}, {28'h0, c1.drive_a, c1.drive_b});
		chk("off", {30'h0, fo0, fo1}, {30'h0, c0.format == OPCR_FMT_OFF,
			c1.format == OPCR_FMT_OFF});
	endtask : chk_ports
	// reset values on ports and in readback
	task automatic t_reset();
		opcr_chan_s c;
		c = '{OPCR_FMT_ACDIFF, 2'h2, 2'h0};
		chk_ports(1'b1, c, c);
		rd(a_first, 32'h0000_00b0);
		rd(a_second, 32'h0000_0030);
	endtask : t_reset
	// every code of every field, back to back, reserved bits written as ones in the second register, only bit 0 in the first
	task automatic t_codes();
		opcr_chan_s c0, c1;
		for (int i = 0; i < 4; i++) begin
			c0 = '{opcr_fmt_e'(i), 2'(3 - i), 2'(i)};
			c1 = '{opcr_fmt_e'(3 - i), 2'(i), 2'(3 - i)};
			wr(a_first, enc(i[0], c0) | 32'h0000_0001);
			wr(a_second, enc(1'b1, c1) | 32'hffff_ff01);
			@(negedge hclk);
			chk_ports(i[0], c0, c1);
			rd(a_first, enc(i[0], c0));
			rd(a_second, enc(1'b0, c1));
		end
	endtask : t_codes
	// byte size, misaligned and unmapped accesses leave the registers alone
	task automatic t_refused();
		logic [31:0] r;
		xfer(a_first, 1'b1, 3'h0, 32'h0000_0000, r);
		wr(32'h0000_007d, 32'h0000_0000);
		wr(32'h0000_047c, 32'h0000_0000);
		wr(32'h0000_0084, 32'h0000_00ff);
		rd(32'h0000_0084, 32'h0000_0000);
		rd(a_first, enc(1'b1, '{OPCR_FMT_CMOS, 2'h0, 2'h3}));
	endtask : t_refused
	// clearing both formats turns both channels off
	task automatic t_shutdown();
		opcr_chan_s c0, c1;
		c0 = '{OPCR_FMT_OFF, 2'h3, 2'h3};
		c1 = '{OPCR_FMT_OFF, 2'h0, 2'h0};
		wr(a_first, enc(1'b1, c0));
		wr(a_second, 32'h0000_0000);
		@(negedge hclk);
		chk_ports(1'b1, c0, c1);
	endtask : t_shutdown
	// main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_codes();
		t_refused();
		t_shutdown();
		complete_run();
	end
endmodule : opcr_tb_top
